// ---- hw/wdf_pkg.sv ----
// constants for the watchdog flag and reset countdown block
//
// Behaviour
// R1: a software write of one to the watchdog reset flag never causes a watchdog reset.
// R2: with the watchdog reset enable clear, watchdog activity leaves the watchdog reset flag alone.
// R3: a watchdog timeout sets the watchdog interrupt flag to one.
// R4: with the interrupt flag set, the two enables pick interrupt, countdown reset, both or neither.
// R5: a zero-to-one change of the interrupt flag starts a reset countdown of 512 clock cycles.
// R6: software that wants no reset writes the restart bit before the 512-cycle countdown ends.
// R7: software setting the interrupt flag raises an interrupt if enabled and starts the countdown.
// R8: software clears the interrupt flag before leaving its handler, or another interrupt follows.
// R9: once started, only the restart bit stops the countdown; clearing the flag does not.
// R10: a watchdog-caused device reset sets the watchdog reset flag.
// R11: the watchdog reset enable is one after power-on reset and keeps its value across others.
// R12: only the first software write to the watchdog reset enable takes effect.
// R13: a countdown that ends with the reset enable set resets the device and sets the reset flag.
package wdf_pkg;

	// ****************************************
	// register bus shape
	// ****************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK = 4'h2;
	localparam logic [3:0] ADDR_CDOWN = 4'h3;

	// control register fields
	localparam int CTRL_IE = 0;
	localparam int CTRL_RE = 1;
	localparam int CTRL_RF = 2;
	localparam int CTRL_IF = 3;
	localparam int CTRL_RESTART = 4;
	localparam int CTRL_CD_ACTIVE = 5;
	localparam int CTRL_RE_LOCKED = 6;

	// event status fields
	localparam int NUM_EVT = 4;
	localparam int ST_WD_IRQ = 0;
	localparam int ST_CD_START = 1;
	localparam int ST_WD_RESET = 2;
	localparam int ST_TIMEOUT = 3;

	// ****************************************
	// reset values and timing
	// ****************************************
	localparam logic RE_RESET = 1'b1;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam int CD_W = 10;
	localparam logic [9:0] RESET_CYCLES = 10'h200;
	localparam int TMR_W = 24;
	localparam int WD_PERIOD_DEFAULT = 32768;

	// countdown states
	typedef enum logic [1:0]
	{
		CD_IDLE = 2'b01,
		CD_RUN = 2'b10
	} wdf_cd_state_type;

endpackage

// ---- hw/wdf_if.sv ----
// signals between the watchdog top and its countdown and interrupt units
interface wdf_if;
	logic cd_start;
	logic cd_restart;
	logic cd_active;
	logic cd_expire;
	logic [9:0] cd_remaining;
	logic [3:0] evt;
	logic st_clear;
	logic [3:0] mask;
	logic [3:0] status;
	logic irq;

	modport top
	(
		output cd_start, cd_restart, evt, st_clear, mask,
		input cd_active, cd_expire, cd_remaining, status, irq
	);
	modport cd
	(
		input cd_start, cd_restart,
		output cd_active, cd_expire, cd_remaining
	);
	modport irqu
	(
		input evt, st_clear, mask,
		output status, irq
	);
endinterface

// ---- hw/wdf_countdown.sv ----
// 512-cycle reset countdown started by the interrupt flag rising
module wdf_countdown
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link to top
	wdf_if.cd bus
);
	wdf_pkg::wdf_cd_state_type state_r;
	logic [9:0] cnt_r;
	logic expire_r;
	wire logic at_end;

	// last cycle of a running countdown
	assign at_end = (state_r == wdf_pkg::CD_RUN) && (cnt_r == 10'h000);
	assign bus.cd_active = (state_r == wdf_pkg::CD_RUN);
	assign bus.cd_expire = expire_r;
	assign bus.cd_remaining = cnt_r;

	// countdown sequencer, restart wins over start
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= wdf_pkg::CD_IDLE;
			cnt_r <= 10'h000;
			expire_r <= 1'b0;
		end
		else
		begin
			expire_r <= 1'b0;
			case (state_r)
				wdf_pkg::CD_IDLE:
				begin
					if (bus.cd_start && !bus.cd_restart)
					begin
						state_r <= wdf_pkg::CD_RUN; // R5
						cnt_r <= wdf_pkg::RESET_CYCLES - 10'h001; // R5
					end
				end
				wdf_pkg::CD_RUN:
				begin
					if (bus.cd_restart)
					begin
						state_r <= wdf_pkg::CD_IDLE; // R9
						cnt_r <= 10'h000;
					end
					else if (at_end)
					begin
						state_r <= wdf_pkg::CD_IDLE;
						expire_r <= 1'b1; // R13
					end
					else
					begin
						cnt_r <= cnt_r - 10'h001;
					end
				end
				default:
				begin
					state_r <= wdf_pkg::CD_IDLE;
					cnt_r <= 10'h000;
				end
			endcase
		end
	end
endmodule

// ---- hw/wdf_irq.sv ----
// sticky event status, mask and level interrupt
module wdf_irq
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// link to top
	wdf_if.irqu bus
);
	logic [3:0] status_r;
	logic irq_r;
	wire logic [3:0] status_nxt;

	// set wins over the read clear
	assign status_nxt = bus.evt | (bus.st_clear ? 4'h0 : status_r);
	assign bus.status = status_r;
	assign bus.irq = irq_r;

	// status and registered interrupt
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			status_r <= 4'h0;
			irq_r <= 1'b0;
		end
		else
		begin
			status_r <= status_nxt;
			irq_r <= |(status_nxt & bus.mask);
		end
	end
endmodule

// ---- hw/wdf_top.sv ----
// watchdog flags, interval timer, reset countdown and register port
module wdf_top
#(
	parameter int WD_PERIOD = wdf_pkg::WD_PERIOD_DEFAULT
)
(
	// clock and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic por_reset,
	// register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// system outputs
	output logic irq,
	output logic sys_reset_req
);

	// ****************************************
	// declarations
	// ****************************************
	wdf_if link();

	// flags and enables
	logic watchdog_interrupt_enable_r;
	logic watchdog_reset_enable_r;
	logic watchdog_reset_flag_r;
	logic watchdog_interrupt_flag_r;
	logic re_locked_r;
	logic [3:0] mask_r;

	// interval timer
	logic [23:0] tmr_r;
	logic timeout_r;

	// outputs
	logic [7:0] rdata_r;
	logic sys_reset_req_r;

	// next values
	wire logic watchdog_interrupt_flag_nxt;
	wire logic watchdog_reset_flag_nxt;
	wire logic watchdog_reset_enable_nxt;
	wire logic [23:0] tmr_nxt;

	// decode
	wire logic sel_ctrl;
	wire logic sel_status;
	wire logic sel_mask;
	wire logic sel_cdown;
	wire logic wr_ctrl;
	wire logic wr_mask;
	wire logic rd_status;
	wire logic restart;
	wire logic tmr_wrap;
	wire logic flag_rise;
	wire logic wd_reset_fire;
	wire logic [7:0] ctrl_view;
	wire logic [7:0] rd_mux;
	localparam logic [23:0] TMR_LAST = 24'(WD_PERIOD - 1);

	// ****************************************
	// register decode
	// ****************************************

	// address match per register
	assign sel_ctrl = (addr == wdf_pkg::ADDR_CTRL);
	assign sel_status = (addr == wdf_pkg::ADDR_STATUS);
	assign sel_mask = (addr == wdf_pkg::ADDR_MASK);
	assign sel_cdown = (addr == wdf_pkg::ADDR_CDOWN);

	// strobes qualified by address
	assign wr_ctrl = wr && sel_ctrl;
	assign wr_mask = wr && sel_mask;
	assign rd_status = rd && sel_status;

	// restart bit is a write-one strobe, it stores nothing
	assign restart = wr_ctrl && wdata[wdf_pkg::CTRL_RESTART]; // R6

	// ****************************************
	// interval timer
	// ****************************************

	// free-running watchdog interval, restarted by software
	assign tmr_wrap = (tmr_r == TMR_LAST);
	assign tmr_nxt = (restart || tmr_wrap) ? 24'h00_0000 : tmr_r + 24'h00_0001;

	// timer counter and registered timeout pulse
	always_ff @(posedge clk or posedge reset or posedge por_reset)
	begin
		if (reset || por_reset)
		begin
			tmr_r <= 24'h00_0000;
			timeout_r <= 1'b0;
		end
		else
		begin
			tmr_r <= tmr_nxt;
			timeout_r <= tmr_wrap && !restart;
		end
	end

	// ****************************************
	// watchdog interrupt flag
	// ****************************************

	// timeout sets, software writes either value, set wins
	assign watchdog_interrupt_flag_nxt = timeout_r
		|| (wr_ctrl ? wdata[wdf_pkg::CTRL_IF] : watchdog_interrupt_flag_r); // R3 R7

	// a zero-to-one change from any source starts the countdown, unless a restart write comes in the same cycle
	assign flag_rise = watchdog_interrupt_flag_nxt && !watchdog_interrupt_flag_r; // R5 R7

	// flag and interrupt enable
	always_ff @(posedge clk or posedge reset or posedge por_reset)
	begin
		if (reset || por_reset)
		begin
			watchdog_interrupt_flag_r <= 1'b0;
			watchdog_interrupt_enable_r <= 1'b0;
			mask_r <= wdf_pkg::MASK_RESET;
		end
		else
		begin
			watchdog_interrupt_flag_r <= watchdog_interrupt_flag_nxt; // R3
			if (wr_ctrl)
			begin
				watchdog_interrupt_enable_r <= wdata[wdf_pkg::CTRL_IE];
			end
			if (wr_mask)
			begin
				mask_r <= wdata[3:0];
			end
		end
	end

	// ****************************************
	// watchdog reset enable, write once
	// ****************************************

	// first control write commits the enable, later ones are dropped
	assign watchdog_reset_enable_nxt = (wr_ctrl && !re_locked_r)
		? wdata[wdf_pkg::CTRL_RE] : watchdog_reset_enable_r; // R12

	// only power-on reset touches these two
	always_ff @(posedge clk or posedge por_reset)
	begin
		if (por_reset)
		begin
			watchdog_reset_enable_r <= wdf_pkg::RE_RESET; // R11
			re_locked_r <= 1'b0;
		end
		else
		begin
			watchdog_reset_enable_r <= watchdog_reset_enable_nxt; // R11 R12
			re_locked_r <= re_locked_r || wr_ctrl; // R12
		end
	end

	// ****************************************
	// reset countdown and device reset
	// ****************************************

	// countdown start and stop requests
	assign link.cd_start = flag_rise; // R5
	assign link.cd_restart = restart; // R9

	// expiry resets the device only while enabled
	assign wd_reset_fire = link.cd_expire && watchdog_reset_enable_r; // R4 R13

	// software may store the flag, only expiry sets it by hardware
	assign watchdog_reset_flag_nxt = wd_reset_fire
		|| (wr_ctrl ? wdata[wdf_pkg::CTRL_RF] : watchdog_reset_flag_r); // R1 R2 R10

	// reset cause flag survives every reset but power-on
	always_ff @(posedge clk or posedge por_reset)
	begin
		if (por_reset)
		begin
			watchdog_reset_flag_r <= 1'b0;
		end
		else
		begin
			watchdog_reset_flag_r <= watchdog_reset_flag_nxt; // R10
		end
	end

	// device reset request, one cycle, never from a flag write
	always_ff @(posedge clk or posedge reset or posedge por_reset)
	begin
		if (reset || por_reset)
		begin
			sys_reset_req_r <= 1'b0;
		end
		else
		begin
			sys_reset_req_r <= wd_reset_fire; // R1 R13
		end
	end

	wdf_countdown u_cd
	(
		.clk(clk),
		.reset(reset || por_reset),
		.bus(link.cd)
	);

	// ****************************************
	// interrupt events
	// ****************************************

	// flag with interrupt enable keeps re-raising until cleared
	assign link.evt[wdf_pkg::ST_WD_IRQ] = watchdog_interrupt_flag_r
		&& watchdog_interrupt_enable_r; // R4 R8
	assign link.evt[wdf_pkg::ST_CD_START] = flag_rise;
	assign link.evt[wdf_pkg::ST_WD_RESET] = wd_reset_fire;
	assign link.evt[wdf_pkg::ST_TIMEOUT] = timeout_r;
	assign link.st_clear = rd_status;
	assign link.mask = mask_r;

	wdf_irq u_irq
	(
		.clk(clk),
		.reset(reset || por_reset),
		.bus(link.irqu)
	);

	// ****************************************
	// read path
	// ****************************************

	// control register as seen by software
	assign ctrl_view = {
		1'b0,
		re_locked_r,
		link.cd_active,
		1'b0,
		watchdog_interrupt_flag_r,
		watchdog_reset_flag_r,
		watchdog_reset_enable_r,
		watchdog_interrupt_enable_r
	};

	// read data select, unmapped reads zero
	assign rd_mux = sel_ctrl ? ctrl_view
		: sel_status ? {4'h0, link.status}
		: sel_mask ? {4'h0, mask_r}
		: sel_cdown ? link.cd_remaining[8:1]
		: 8'h00;

	// read data stand one cycle after the strobe only
	always_ff @(posedge clk or posedge reset or posedge por_reset)
	begin
		if (reset || por_reset)
		begin
			rdata_r <= 8'h00;
		end
		else
		begin
			rdata_r <= rd ? rd_mux : 8'h00;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign rdata = rdata_r;
	assign irq = link.irq;
	assign sys_reset_req = sys_reset_req_r;

endmodule

// ---- testbench/wdf_top_assertions.sv ----
// port checks for the watchdog top
module wdf_top_assertions
#(
	parameter int WD_PERIOD = 64
)
(
	// clock and resets
	input wire logic clk,
	input wire logic reset,
	input wire logic por_reset,
	// register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// system outputs
	input wire logic irq,
	input wire logic sys_reset_req
);
	// ****************************************
	// helper state
	// ****************************************
	wire logic ctrl_wr = wr && addr == 4'h0;
	logic seen_r;
	logic re_r;
	logic [9:0] quiet_r;
	logic [3:0] mask_r;

	// first control write and the enable it carried
	always_ff @(posedge clk or posedge por_reset)
	begin
		if (por_reset)
		begin
			seen_r <= 1'b0;
			re_r <= 1'b1;
		end
		else if (ctrl_wr && !reset && !seen_r)
		begin
			seen_r <= 1'b1;
			re_r <= wdata[1];
		end
	end

	// cycles since the last restart, copy of the mask
	always_ff @(posedge clk or posedge reset or posedge por_reset)
	begin
		if (reset || por_reset)
		begin
			quiet_r <= 10'h000;
			mask_r <= 4'h0;
		end
		else
		begin
			if (ctrl_wr && wdata[4])
				quiet_r <= 10'h000;
			else if (quiet_r != 10'h3ff)
				quiet_r <= quiet_r + 10'h001;
			if (wr && addr == 4'h2)
				mask_r <= wdata[3:0];
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (reset || por_reset);

	rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read");
	unmapped_read_a: assert property (rd && addr > 4'h3 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	reset_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
		else $error("reset request longer than one cycle");
	sw_flag_safe_a: assert property (ctrl_wr && wdata[4] && wdata[2] |-> ##2 !sys_reset_req [*7])
		else $error("reset after software flag write");
	quiet_wait_a: assert property (sys_reset_req |-> quiet_r >= 10'h201 || quiet_r == 10'h000)
		else $error("reset request too soon after restart");
	fixed_bits_a: assert property (rd && ctrl_wr == 1'b0 && addr == 4'h0 |=> !rdata[7] && !rdata[4])
		else $error("restart or spare bit reads one");
	enable_por_a: assert property (rd && addr == 4'h0 && !seen_r |=> rdata[1])
		else $error("reset enable not one after power-on");
	enable_lock_a: assert property (rd && addr == 4'h0 && seen_r |=> rdata[1] == re_r && rdata[6])
		else $error("reset enable changed after first write");
	reset_gate_a: assert property (sys_reset_req |-> (seen_r ? re_r : 1'b1))
		else $error("reset request with enable clear");
	irq_mask_a: assert property (irq |-> $past(mask_r) != 4'h0)
		else $error("interrupt while fully masked");
endmodule

bind wdf_top wdf_top_assertions #(.WD_PERIOD(WD_PERIOD)) wdf_top_assertions_inst
(
	.clk(clk), .reset(reset), .por_reset(por_reset), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sys_reset_req(sys_reset_req)
);

// ---- testbench/wdf_top_bench.sv ----
// self-checking bench for the watchdog top
module wdf_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int PERIOD = 2000;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic por_reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic sys_reset_req;
	logic req_seen = 1'b0;
	int miscompares = 0;
	int check_count = 0;
	realtime t0;

	// ****************************************
	// clock, design, request record
	// ****************************************
	always #12.5 clk = ~clk;

	wdf_top #(.WD_PERIOD(PERIOD)) wdf_top_inst
	(
		.clk(clk), .reset(reset), .por_reset(por_reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .sys_reset_req(sys_reset_req)
	);

	// sticky note of any reset request
	always @(posedge clk)
		if (sys_reset_req === 1'b1)
			req_seen <= 1'b1;

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk({8'h00, rdata}, {8'h00, exp});
	endtask

	task automatic irq_is(input logic v);
		repeat (2) @(posedge clk);
		#1;
		chk({15'h0000, irq}, {15'h0000, v});
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard
	initial
	begin
		#250000;
		miscompares++;
		tally_and_finish();
	end

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		por_reset <= 1'b0;
		rd_reg(4'h0, 8'h02);
		wr_reg(4'h7, 8'hff);
		rd_reg(4'h2, 8'h00);
		rd_reg(4'hf, 8'h00);
		wr_reg(4'h0, 8'h16);
		rd_reg(4'h0, 8'h46);
		wr_reg(4'h0, 8'h10);
		rd_reg(4'h0, 8'h42);
		$display("test power-on and lock done");
		wr_reg(4'h2, 8'h01);
		wr_reg(4'h0, 8'h0b);
		t0 = $realtime;
		rd_reg(4'h3, 8'hff);
		irq_is(1'b1);
		rd_reg(4'h0, 8'h6b);
		wr_reg(4'h0, 8'h03);
		rd_reg(4'h0, 8'h63);
		rd_reg(4'h1, 8'h03);
		for (int i = 0; i < 600 && sys_reset_req !== 1'b1; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk(16'($rtoi(($realtime - t0) / 25.0)), 16'h0201);
		rd_reg(4'h0, 8'h47);
		rd_reg(4'h1, 8'h04);
		$display("test countdown reset done");
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd_reg(4'h0, 8'h46);
		req_seen <= 1'b0;
		wr_reg(4'h0, 8'h0a);
		repeat (300) @(posedge clk);
		wr_reg(4'h0, 8'h12);
		repeat (600) @(posedge clk);
		chk({15'h0000, req_seen}, 16'h0000);
		rd_reg(4'h0, 8'h42);
		$display("test restart done");
		@(posedge clk);
		por_reset <= 1'b1;
		repeat (2) @(posedge clk);
		por_reset <= 1'b0;
		wr_reg(4'h0, 8'h08);
		rd_reg(4'h0, 8'h68);
		repeat (600) @(posedge clk);
		chk({15'h0000, req_seen}, 16'h0000);
		rd_reg(4'h0, 8'h48);
		wr_reg(4'h0, 8'h10);
		repeat (PERIOD + 10) @(posedge clk);
		rd_reg(4'h0, 8'h68);
		irq_is(1'b0);
		wr_reg(4'h2, 8'h08);
		irq_is(1'b1);
		rd_reg(4'h1, 8'h0a);
		irq_is(1'b0);
		$display("test timeout done");
		wr_reg(4'h0, 8'h09);
		wr_reg(4'h2, 8'h01);
		rd_reg(4'h1, 8'h01);
		irq_is(1'b1);
		wr_reg(4'h0, 8'h01);
		rd_reg(4'h1, 8'h01);
		rd_reg(4'h1, 8'h00);
		irq_is(1'b0);
		rd_reg(4'h0, 8'h61);
		$display("test interrupt re-raise done");
		tally_and_finish();
	end
endmodule
